// *** hdl/local_mem_consts.svh ***
// timing, segment and field constants for the local memory controller
`ifndef LOCAL_MEM_CONSTS_SVH
`define LOCAL_MEM_CONSTS_SVH
`define SEG_PROM_LO 7'h00
`define SEG_PROM_HI 7'h11
`define SEG_RAM_LO 7'h03
`define SEG_RAM_HI 7'h05
`define SEG_SYSBUS 7'h09
`define ROW_MSB 15
`define ROW_LSB 8
`define COL_MSB 7
`define COL_LSB 0
`define PROM_ADDR_MSB 12
`define PROM_ADDR_LSB 1
`define REFRESH_PERIOD_NS 15600
`define CLK_PERIOD_NS 10
`define REFRESH_CYCLES (`REFRESH_PERIOD_NS / `CLK_PERIOD_NS)
`define REFRESH_CNT_W 11
`define ROW_PHASE_CYCLES 4'h2
`define COL_PHASE_CYCLES 4'h3
`define PRECHARGE_CYCLES 4'h2
`define CNT_W 4
`endif

// *** hdl/local_mem_pkg.sv ***
// types for the local memory controller
package local_mem_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ROW = 3'b001,
        ST_COL = 3'b011,
        ST_PRE = 3'b010,
        ST_REF = 3'b110
    } mem_state_t;
    typedef enum logic [1:0] {
        OWN_CPU = 2'b00,
        OWN_SEQ = 2'b01,
        OWN_REF = 2'b10
    } mem_owner_t;
    typedef enum logic [2:0] {
        SPACE_NONE = 3'b000,
        SPACE_PROM = 3'b001,
        SPACE_RAM_LO = 3'b010,
        SPACE_RAM_HI = 3'b011,
        SPACE_SYSBUS = 3'b100
    } mem_space_t;
endpackage

// *** hdl/parity_ram_bank.sv ***
// 16 one-bit ram columns plus two parity columns for one half of local ram
`timescale 1ns/1ps
module parity_ram_bank (
    input wire logic i_sys_clk,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [1:0] i_wpar,
    input wire logic i_row_strobe_n,
    input wire logic i_column_strobe_even_n,
    input wire logic i_column_strobe_odd_n,
    input wire logic i_wr_hi_n,
    input wire logic i_wr_lo_n,
    output logic [15:0] o_rdata,
    output logic [1:0] o_rpar
);
    wire logic [17:0] bits_rd;
    // bit 16 is the low-byte parity column, bit 17 the high-byte one
    genvar g;
    generate
        for (g = 0; g < 18; g++) begin : g_col
            logic mem [0:65535];
            logic hi;
            logic wr_n;
            logic cas_n;
            logic din;
            logic bit_r;
            assign hi = (g >= 8 && g < 16) || (g == 17);
            assign wr_n = hi ? i_wr_hi_n : i_wr_lo_n;
            assign cas_n = hi ? i_column_strobe_odd_n : i_column_strobe_even_n;
            // modulo keeps the unused branch index in range
            assign din = (g < 16) ? i_wdata[g % 16] : i_wpar[g % 2];
            assign bits_rd[g] = bit_r;
            always_ff @(posedge i_sys_clk) begin
                if (!i_row_strobe_n && !cas_n) begin
                    if (!wr_n) begin
                        mem[i_addr] <= din;
                    end
                    bit_r <= mem[i_addr];
                end
            end
        end
    endgenerate
    assign o_rdata = bits_rd[15:0];
    assign o_rpar = bits_rd[17:16];
endmodule

// *** hdl/local_dram_parity_prom_ctrl.sv ***
// local memory controller: segment decode, ram timing, parity, arbitration
//
// Behaviour
// - segment 3 low ram, segment 5 high
// - segment 9 forwarded to system bus
// - segment lines decoded binary; prom 0, 17
// - word stored across sixteen one-bit columns
// - address muxed into 8-bit row, column
// - byte access strobes only its column
// - separate direction per byte lane
// - writes store even parity per byte
// - read parity mismatch raises fault and nmi
// - processor waits while sequencer owns memory
// - processor and sequencer alternate memory cycles
// - dma requests formally; processor releases first
// - prom 4k words, address bits 1-12
// - both prom bytes share address, enable
`timescale 1ns/1ps
`include "local_mem_consts.svh"
module local_dram_parity_prom_ctrl
    import local_mem_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // processor side (tape dma drives these same pins once granted)
    input wire logic i_cpu_req,
    input wire logic [6:0] i_segment_number_lines,
    input wire logic [15:0] i_local_address_bus,
    input wire logic i_cpu_write,
    input wire logic i_cpu_byte,
    input wire logic [15:0] i_cpu_wdata,
    input wire logic i_parity_enable,
    input wire logic i_parity_clear,
    input wire logic i_dma_req,
    input wire logic i_cpu_released,
    // disk sequencer side
    input wire logic i_seq_req,
    input wire logic [16:0] i_seq_addr,
    input wire logic i_seq_write,
    input wire logic [15:0] i_seq_wdata,
    output logic o_cpu_wait,
    output logic o_cpu_done,
    output logic o_seq_done,
    output logic [15:0] o_rdata,
    output logic o_dma_grant,
    output logic o_sysbus_sel,
    output logic [11:0] o_prom_addr,
    output logic o_prom_bank_enable_n,
    output logic [7:0] o_muxed_dram_address,
    output logic o_row_strobe_lo_n,
    output logic o_row_strobe_hi_n,
    output logic o_column_strobe_even_n,
    output logic o_column_strobe_odd_n,
    output logic o_dir_hi_n,
    output logic o_dir_lo_n,
    output logic o_parity_fault,
    output logic o_nmi_n
);
    function automatic mem_space_t decode_space(input logic [6:0] seg);
        unique case (seg)
            `SEG_PROM_LO, `SEG_PROM_HI: decode_space = SPACE_PROM;
            `SEG_RAM_LO: decode_space = SPACE_RAM_LO;
            `SEG_RAM_HI: decode_space = SPACE_RAM_HI;
            `SEG_SYSBUS: decode_space = SPACE_SYSBUS;
            default: decode_space = SPACE_NONE;
        endcase
    endfunction

    function automatic logic even_par(input logic [7:0] b);
        even_par = ^b;
    endfunction

    mem_space_t cpu_space;
    logic cpu_ram;
    assign cpu_space = decode_space(i_segment_number_lines);
    assign cpu_ram = i_cpu_req && (cpu_space == SPACE_RAM_LO || cpu_space == SPACE_RAM_HI);

    // memory cycle state
    mem_state_t state_r, state_nxt;
    mem_owner_t owner_r, owner_nxt;
    logic last_seq_r, last_seq_nxt;
    logic [`CNT_W-1:0] cnt_r, cnt_nxt;
    logic [`REFRESH_CNT_W-1:0] ref_cnt_r, ref_cnt_nxt;
    logic ref_pend_r, ref_pend_nxt;
    logic [7:0] ref_row_r, ref_row_nxt;
    logic [16:0] addr_r, addr_nxt;
    logic write_r, write_nxt;
    logic byte_r, byte_nxt;
    logic [15:0] wdata_r, wdata_nxt;
    logic cpu_done_r, cpu_done_nxt;
    logic seq_done_r, seq_done_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic check_r, check_nxt;
    logic fault_r, fault_nxt;
    logic nmi_n_r, nmi_n_nxt;
    logic dma_grant_r, dma_grant_nxt;
    logic cpu_wait_r, cpu_wait_nxt;
    logic [7:0] muxed_dram_address_r, muxed_dram_address_nxt;
    logic ras_lo_n_r, ras_lo_n_nxt;
    logic ras_hi_n_r, ras_hi_n_nxt;
    logic cas_e_n_r, cas_e_n_nxt;
    logic cas_o_n_r, cas_o_n_nxt;
    logic dir_hi_n_r, dir_hi_n_nxt;
    logic dir_lo_n_r, dir_lo_n_nxt;
    logic sysbus_r, sysbus_nxt;
    logic [11:0] prom_addr_r, prom_addr_nxt;
    logic prom_en_n_r, prom_en_n_nxt;

    logic [15:0] rd_lo, rd_hi;
    logic [1:0] rp_lo, rp_hi;
    logic [15:0] rd_sel;
    logic [1:0] rp_sel;
    logic [1:0] wpar;

    assign wpar = {even_par(wdata_r[15:8]), even_par(wdata_r[7:0])};
    assign rd_sel = addr_r[16] ? rd_hi : rd_lo;
    assign rp_sel = addr_r[16] ? rp_hi : rp_lo;

    always_comb begin
        logic take_seq;
        logic take_cpu;
        take_seq = 1'b0;
        take_cpu = 1'b0;
        state_nxt = state_r;
        owner_nxt = owner_r;
        last_seq_nxt = last_seq_r;
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        write_nxt = write_r;
        byte_nxt = byte_r;
        wdata_nxt = wdata_r;
        cpu_done_nxt = 1'b0;
        seq_done_nxt = 1'b0;
        rdata_nxt = rdata_r;
        check_nxt = 1'b0;
        muxed_dram_address_nxt = muxed_dram_address_r;
        ras_lo_n_nxt = ras_lo_n_r;
        ras_hi_n_nxt = ras_hi_n_r;
        cas_e_n_nxt = cas_e_n_r;
        cas_o_n_nxt = cas_o_n_r;
        dir_hi_n_nxt = dir_hi_n_r;
        dir_lo_n_nxt = dir_lo_n_r;
        ref_row_nxt = ref_row_r;
        ref_pend_nxt = ref_pend_r;
        ref_cnt_nxt = ref_cnt_r + 1'b1;
        if (ref_cnt_r == `REFRESH_CNT_W'(`REFRESH_CYCLES - 1)) begin
            ref_cnt_nxt = '0;
            ref_pend_nxt = 1'b1;
        end
        unique case (state_r)
            ST_IDLE: begin
                if (ref_pend_r) begin
                    owner_nxt = OWN_REF;
                    ref_pend_nxt = 1'b0;
                    muxed_dram_address_nxt = ref_row_r;
                    state_nxt = ST_REF;
                    cnt_nxt = `ROW_PHASE_CYCLES;
                end else begin
                    // alternate when both want the memory
                    take_seq = i_seq_req && (!cpu_ram || !last_seq_r);
                    take_cpu = cpu_ram && !take_seq;
                    if (take_seq) begin
                        owner_nxt = OWN_SEQ;
                        last_seq_nxt = 1'b1;
                        addr_nxt = i_seq_addr;
                        write_nxt = i_seq_write;
                        byte_nxt = 1'b0;
                        wdata_nxt = i_seq_wdata;
                    end else if (take_cpu) begin
                        owner_nxt = OWN_CPU;
                        last_seq_nxt = 1'b0;
                        addr_nxt = {cpu_space == SPACE_RAM_HI, i_local_address_bus};
                        write_nxt = i_cpu_write;
                        byte_nxt = i_cpu_byte;
                        wdata_nxt = i_cpu_wdata;
                    end
                    if (take_seq || take_cpu) begin
                        // row address presented before its strobe
                        muxed_dram_address_nxt = take_seq ? i_seq_addr[`ROW_MSB:`ROW_LSB]
                                            : i_local_address_bus[`ROW_MSB:`ROW_LSB];
                        state_nxt = ST_ROW;
                        cnt_nxt = `ROW_PHASE_CYCLES;
                    end
                end
            end
            ST_ROW: begin
                ras_lo_n_nxt = addr_r[16];
                ras_hi_n_nxt = !addr_r[16];
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == `CNT_W'(1)) begin
                    // both byte halves of one word share a column
                    muxed_dram_address_nxt = {addr_r[`COL_MSB:1], addr_r[0] && !byte_r};
                    state_nxt = ST_COL;
                    cnt_nxt = `COL_PHASE_CYCLES;
                end
            end
            ST_COL: begin
                // column strobes follow the row strobe
                cas_e_n_nxt = byte_r && addr_r[0];
                cas_o_n_nxt = byte_r && !addr_r[0];
                dir_lo_n_nxt = !(write_r && !(byte_r && addr_r[0]));
                dir_hi_n_nxt = !(write_r && !(byte_r && !addr_r[0]));
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == `CNT_W'(1)) begin
                    rdata_nxt = rd_sel;
                    check_nxt = !write_r;
                    cpu_done_nxt = (owner_r == OWN_CPU);
                    seq_done_nxt = (owner_r == OWN_SEQ);
                    state_nxt = ST_PRE;
                    cnt_nxt = `PRECHARGE_CYCLES;
                end
            end
            ST_PRE: begin
                ras_lo_n_nxt = 1'b1;
                ras_hi_n_nxt = 1'b1;
                cas_e_n_nxt = 1'b1;
                cas_o_n_nxt = 1'b1;
                dir_hi_n_nxt = 1'b1;
                dir_lo_n_nxt = 1'b1;
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == `CNT_W'(1)) begin
                    state_nxt = ST_IDLE;
                    owner_nxt = OWN_CPU;
                end
            end
            ST_REF: begin
                // ras-only refresh of both halves
                ras_lo_n_nxt = 1'b0;
                ras_hi_n_nxt = 1'b0;
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == `CNT_W'(1)) begin
                    ref_row_nxt = ref_row_r + 1'b1;
                    state_nxt = ST_PRE;
                    cnt_nxt = `PRECHARGE_CYCLES;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // parity check, dma handover, prom and system bus decode
    always_comb begin
        logic mism;
        mism = check_r && i_parity_enable &&
               (rp_sel != {even_par(rdata_r[15:8]), even_par(rdata_r[7:0])});
        fault_nxt = fault_r;
        if (i_parity_clear) begin
            fault_nxt = 1'b0;
        end
        if (mism) begin
            fault_nxt = 1'b1;
        end
        nmi_n_nxt = !fault_nxt;
        // grant only once the processor has floated its outputs
        dma_grant_nxt = i_dma_req && i_cpu_released;
        cpu_wait_nxt = (owner_nxt == OWN_SEQ && state_nxt != ST_IDLE) ||
                       (cpu_ram && !cpu_done_nxt);
        sysbus_nxt = i_cpu_req && cpu_space == SPACE_SYSBUS;
        prom_addr_nxt = i_local_address_bus[`PROM_ADDR_MSB:`PROM_ADDR_LSB];
        prom_en_n_nxt = !(i_cpu_req && cpu_space == SPACE_PROM && !i_cpu_write);
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
            owner_r <= OWN_CPU;
            last_seq_r <= 1'b0;
            cnt_r <= '0;
            ref_cnt_r <= '0;
            ref_pend_r <= 1'b0;
            ref_row_r <= 8'h00;
            addr_r <= 17'h0_0000;
            write_r <= 1'b0;
            byte_r <= 1'b0;
            wdata_r <= 16'h0000;
            cpu_done_r <= 1'b0;
            seq_done_r <= 1'b0;
            rdata_r <= 16'h0000;
            check_r <= 1'b0;
            fault_r <= 1'b0;
            nmi_n_r <= 1'b1;
            dma_grant_r <= 1'b0;
            cpu_wait_r <= 1'b0;
            muxed_dram_address_r <= 8'h00;
            ras_lo_n_r <= 1'b1;
            ras_hi_n_r <= 1'b1;
            cas_e_n_r <= 1'b1;
            cas_o_n_r <= 1'b1;
            dir_hi_n_r <= 1'b1;
            dir_lo_n_r <= 1'b1;
            sysbus_r <= 1'b0;
            prom_addr_r <= 12'h000;
            prom_en_n_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            owner_r <= owner_nxt;
            last_seq_r <= last_seq_nxt;
            cnt_r <= cnt_nxt;
            ref_cnt_r <= ref_cnt_nxt;
            ref_pend_r <= ref_pend_nxt;
            ref_row_r <= ref_row_nxt;
            addr_r <= addr_nxt;
            write_r <= write_nxt;
            byte_r <= byte_nxt;
            wdata_r <= wdata_nxt;
            cpu_done_r <= cpu_done_nxt;
            seq_done_r <= seq_done_nxt;
            rdata_r <= rdata_nxt;
            check_r <= check_nxt;
            fault_r <= fault_nxt;
            nmi_n_r <= nmi_n_nxt;
            dma_grant_r <= dma_grant_nxt;
            cpu_wait_r <= cpu_wait_nxt;
            muxed_dram_address_r <= muxed_dram_address_nxt;
            ras_lo_n_r <= ras_lo_n_nxt;
            ras_hi_n_r <= ras_hi_n_nxt;
            cas_e_n_r <= cas_e_n_nxt;
            cas_o_n_r <= cas_o_n_nxt;
            dir_hi_n_r <= dir_hi_n_nxt;
            dir_lo_n_r <= dir_lo_n_nxt;
            sysbus_r <= sysbus_nxt;
            prom_addr_r <= prom_addr_nxt;
            prom_en_n_r <= prom_en_n_nxt;
        end
    end

    // two ram halves, each with its own row strobe
    parity_ram_bank u_bank_lo (
        .i_sys_clk(i_sys_clk),
        .i_addr({addr_r[`ROW_MSB:`ROW_LSB], muxed_dram_address_r}),
        .i_wdata(wdata_r),
        .i_wpar(wpar),
        .i_row_strobe_n(ras_lo_n_r),
        .i_column_strobe_even_n(cas_e_n_r),
        .i_column_strobe_odd_n(cas_o_n_r),
        .i_wr_hi_n(dir_hi_n_r),
        .i_wr_lo_n(dir_lo_n_r),
        .o_rdata(rd_lo),
        .o_rpar(rp_lo)
    );
    parity_ram_bank u_bank_hi (
        .i_sys_clk(i_sys_clk),
        .i_addr({addr_r[`ROW_MSB:`ROW_LSB], muxed_dram_address_r}),
        .i_wdata(wdata_r),
        .i_wpar(wpar),
        .i_row_strobe_n(ras_hi_n_r),
        .i_column_strobe_even_n(cas_e_n_r),
        .i_column_strobe_odd_n(cas_o_n_r),
        .i_wr_hi_n(dir_hi_n_r),
        .i_wr_lo_n(dir_lo_n_r),
        .o_rdata(rd_hi),
        .o_rpar(rp_hi)
    );

    assign o_cpu_wait = cpu_wait_r;
    assign o_cpu_done = cpu_done_r;
    assign o_seq_done = seq_done_r;
    assign o_rdata = rdata_r;
    assign o_dma_grant = dma_grant_r;
    assign o_sysbus_sel = sysbus_r;
    assign o_prom_addr = prom_addr_r;
    assign o_prom_bank_enable_n = prom_en_n_r;
    assign o_muxed_dram_address = muxed_dram_address_r;
    assign o_row_strobe_lo_n = ras_lo_n_r;
    assign o_row_strobe_hi_n = ras_hi_n_r;
    assign o_column_strobe_even_n = cas_e_n_r;
    assign o_column_strobe_odd_n = cas_o_n_r;
    assign o_dir_hi_n = dir_hi_n_r;
    assign o_dir_lo_n = dir_lo_n_r;
    assign o_parity_fault = fault_r;
    assign o_nmi_n = nmi_n_r;
endmodule

// *** verification/mem_ctrl_chk.sv ***
// port assertions for the local memory controller
`timescale 1ns/1ps
module mem_ctrl_chk (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_cpu_req,
    input wire logic [6:0] i_segment_number_lines,
    input wire logic [15:0] i_local_address_bus,
    input wire logic i_cpu_write,
    input wire logic i_dma_req,
    input wire logic i_cpu_released,
    input wire logic o_cpu_wait,
    input wire logic o_cpu_done,
    input wire logic o_seq_done,
    input wire logic o_dma_grant,
    input wire logic o_sysbus_sel,
    input wire logic [11:0] o_prom_addr,
    input wire logic o_prom_bank_enable_n,
    input wire logic o_row_strobe_lo_n,
    input wire logic o_row_strobe_hi_n,
    input wire logic o_column_strobe_even_n,
    input wire logic o_column_strobe_odd_n,
    input wire logic o_dir_hi_n,
    input wire logic o_dir_lo_n
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    logic ras_on, cas_on, ram_req, prom_rd;
    assign ras_on = !o_row_strobe_lo_n || !o_row_strobe_hi_n;
    assign cas_on = !o_column_strobe_even_n || !o_column_strobe_odd_n;
    assign ram_req = i_cpu_req && (i_segment_number_lines inside {7'h03, 7'h05});
    assign prom_rd = i_cpu_req && !i_cpu_write && (i_segment_number_lines inside {7'h00, 7'h11});
    a_row_before_col: assert property ($rose(cas_on) |-> ras_on && $past(ras_on, 2))
        else $error("column strobe without settled row strobe");
    a_col_to_done: assert property ($rose(cas_on) |-> ##2 (o_cpu_done || o_seq_done))
        else $error("no done two cycles after column strobe");
    a_dir_hi_lane: assert property ($fell(o_dir_hi_n) |-> $fell(o_column_strobe_odd_n))
        else $error("high lane direction without odd strobe");
    a_dir_lo_lane: assert property ($fell(o_dir_lo_n) |-> $fell(o_column_strobe_even_n))
        else $error("low lane direction without even strobe");
    a_seq_holds_cpu: assert property (o_seq_done && ram_req && $past(ram_req) |-> o_cpu_wait)
        else $error("processor not waiting while sequencer owns memory");
    a_dma_grant_cause: assert property ($rose(o_dma_grant) |-> $past(i_dma_req && i_cpu_released))
        else $error("dma granted before request and release");
    a_prom_enable: assert property (i_cpu_req |=> o_prom_bank_enable_n == !$past(prom_rd))
        else $error("prom bank enable wrong");
    a_prom_word_addr: assert property (i_cpu_req |=> o_prom_addr == $past(i_local_address_bus[12:1]))
        else $error("prom address not bits 12 to 1");
    a_sysbus_window: assert property (i_cpu_req |=> o_sysbus_sel == $past(i_segment_number_lines == 7'h09))
        else $error("system bus select wrong");
    c_cpu_done: cover property (o_cpu_done);
    c_seq_done: cover property (o_seq_done);
    c_odd_byte: cover property (!o_column_strobe_odd_n && o_column_strobe_even_n);
    c_dma: cover property ($rose(o_dma_grant));
endmodule

bind local_dram_parity_prom_ctrl mem_ctrl_chk u_chk (.*);

// *** verification/cpu_port_model.sv ***
// processor and tape dma requester on the local memory port
`timescale 1ns/1ps
module cpu_port_model (
    input wire logic i_sys_clk,
    input wire logic i_done,
    input wire logic i_grant,
    input wire logic [15:0] i_rdata,
    output logic o_req,
    output logic [6:0] o_seg,
    output logic [15:0] o_addr,
    output logic o_write,
    output logic o_byte,
    output logic [15:0] o_wdata,
    output logic o_dma_req,
    output logic o_released
);
    initial {o_req, o_seg, o_addr, o_write, o_byte, o_wdata, o_dma_req, o_released} = '0;
    // hold > 0: drive that many cycles with no done expected
    task automatic access(input logic [6:0] seg, input logic [15:0] addr, input logic wr, byt,
                          input logic [15:0] wd, input logic dma, input int hold,
                          output logic [15:0] rd, output logic ok);
        int n;
        n = 0;
        if (dma) begin
            @(posedge i_sys_clk) o_dma_req <= 1'b1;
            @(posedge i_sys_clk) o_released <= 1'b1;
            do @(posedge i_sys_clk); while (i_grant !== 1'b1 && ++n < 20);
        end else begin
            @(posedge i_sys_clk);
        end
        {o_req, o_seg, o_addr, o_write, o_byte, o_wdata} <= {1'b1, seg, addr, wr, byt, wd};
        if (hold > 0) repeat (hold) @(posedge i_sys_clk);
        else do @(posedge i_sys_clk); while (i_done !== 1'b1 && ++n < 120);
        ok = (hold > 0 || i_done === 1'b1) && (!dma || i_grant === 1'b1);
        rd = i_rdata;
        {o_req, o_dma_req, o_released} <= 3'b000;
        o_addr <= ~addr;
        o_wdata <= ~wd;
    endtask
endmodule

// *** verification/tb.sv ***
// self-checking bench for the local memory controller
`timescale 1ns/1ps
`include "local_mem_consts.svh"
module tb;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_parity_enable = 1'b1;
    logic i_parity_clear = 1'b1;
    logic i_seq_req = 1'b0;
    logic i_seq_write = 1'b0;
    logic [16:0] i_seq_addr = 17'h0_0000;
    logic [15:0] i_seq_wdata = 16'h0000;
    logic i_cpu_req, i_cpu_write, i_cpu_byte, i_dma_req, i_cpu_released;
    logic [6:0] i_segment_number_lines;
    logic [15:0] i_local_address_bus, i_cpu_wdata, o_rdata;
    logic o_cpu_wait, o_cpu_done, o_seq_done, o_dma_grant, o_sysbus_sel, o_prom_bank_enable_n;
    logic o_row_strobe_lo_n, o_row_strobe_hi_n, o_column_strobe_even_n, o_column_strobe_odd_n;
    logic o_dir_hi_n, o_dir_lo_n, o_parity_fault, o_nmi_n;
    logic [11:0] o_prom_addr;
    logic [7:0] o_muxed_dram_address, row_seen, col_seen;
    logic [5:0] strb;
    logic [5:0] strb_q = 6'h3f;
    int num_errors = 0;
    int checked = 0;
    int waits = 0;
    int falls [6] = '{default: 0};
    string order = "";

    always #5 i_sys_clk = ~i_sys_clk;
    assign strb = {o_row_strobe_lo_n, o_row_strobe_hi_n, o_column_strobe_even_n,
                   o_column_strobe_odd_n, o_dir_hi_n, o_dir_lo_n};

    local_dram_parity_prom_ctrl uut (.*);
    cpu_port_model pm (
        .i_sys_clk(i_sys_clk), .i_done(o_cpu_done), .i_grant(o_dma_grant), .i_rdata(o_rdata),
        .o_req(i_cpu_req), .o_seg(i_segment_number_lines), .o_addr(i_local_address_bus),
        .o_write(i_cpu_write), .o_byte(i_cpu_byte), .o_wdata(i_cpu_wdata),
        .o_dma_req(i_dma_req), .o_released(i_cpu_released)
    );

    // strobe falls, row and column seen, order of completions
    always @(negedge i_sys_clk) begin
        for (int k = 0; k < 6; k++) if (strb_q[k] === 1'b1 && strb[k] === 1'b0) falls[k]++;
        if (strb_q[5:4] === 2'b11 && strb[5:4] !== 2'b11) row_seen = o_muxed_dram_address;
        if (strb_q[3:2] === 2'b11 && strb[3:2] !== 2'b11) col_seen = o_muxed_dram_address;
        if (o_cpu_done === 1'b1) order = {order, "c"};
        if (o_seq_done === 1'b1) order = {order, "s"};
        waits += int'(o_cpu_wait === 1'b1);
        strb_q = strb;
    end

    task automatic stop_test();
        if (num_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic good, input string msg);
        checked++;
        if (good !== 1'b1) begin
            num_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    task automatic ram(input logic [6:0] s, input logic [15:0] a, input logic wr, byt,
                       input logic [15:0] wd, input logic dma, output logic [15:0] rd);
        logic ok;
        pm.access(s, a, wr, byt, wd, dma, 0, rd, ok);
        chk(ok === 1'b1, "ram access unanswered");
    endtask

    task automatic seq_access(input logic [16:0] a, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        {i_seq_req, i_seq_addr, i_seq_write, i_seq_wdata} <= {1'b1, a, 1'b1, wd};
        do @(posedge i_sys_clk); while (o_seq_done !== 1'b1 && ++n < 120);
        i_seq_req <= 1'b0;
        i_seq_addr <= ~a;
        chk(n < 120, "sequencer unanswered");
    endtask

    task automatic t_words();
        logic [15:0] a [4] = '{16'h5a3c, 16'hfffe, 16'h0000, 16'h8102};
        logic [15:0] rd;
        for (int k = 0; k < 4; k++) begin
            ram(7'h03, a[k], 1'b1, 1'b0, a[k] ^ 16'h0f0f, 1'b0, rd);
            ram(7'h05, a[k], 1'b1, 1'b0, ~a[k], 1'b0, rd);
        end
        for (int k = 0; k < 4; k++) begin
            ram(7'h03, a[k], 1'b0, 1'b0, 16'h0000, 1'b0, rd);
            chk(rd === (a[k] ^ 16'h0f0f), "low half data");
            chk(row_seen === a[k][15:8] && col_seen === a[k][7:0], "row or column");
            ram(7'h05, a[k], 1'b0, 1'b0, 16'h0000, 1'b0, rd);
            chk(rd === ~a[k], "high half data");
        end
        chk(o_parity_fault === 1'b0 && o_nmi_n === 1'b1, "false parity fault");
    endtask

    task automatic t_bytes();
        int f0 [6];
        logic [15:0] rd;
        ram(7'h03, 16'h0200, 1'b1, 1'b0, 16'h1122, 1'b0, rd);
        f0 = falls;
        ram(7'h03, 16'h0201, 1'b1, 1'b1, 16'habab, 1'b0, rd);
        chk(falls[2] - f0[2] === 1 && falls[3] === f0[3], "odd byte strobes");
        chk(falls[1] - f0[1] === 1 && falls[0] === f0[0], "odd byte lanes");
        f0 = falls;
        ram(7'h03, 16'h0200, 1'b1, 1'b1, 16'hcdcd, 1'b0, rd);
        chk(falls[3] - f0[3] === 1 && falls[2] === f0[2], "even byte strobes");
        chk(falls[0] - f0[0] === 1 && falls[1] === f0[1], "even byte lanes");
        ram(7'h03, 16'h0200, 1'b0, 1'b0, 16'h0000, 1'b0, rd);
        chk(rd === 16'habcd, "byte merge");
    endtask

    task automatic t_decode();
        logic [6:0] s [4] = '{7'h00, 7'h11, 7'h10, 7'h09};
        logic [15:0] rd;
        logic ok;
        for (int k = 0; k < 4; k++) begin
            pm.access(s[k], 16'h2ab7, 1'b0, 1'b0, 16'h0000, 1'b0, 2, rd, ok);
            chk(o_prom_bank_enable_n === (k > 1), "prom enable");
            chk(o_prom_addr === 12'h55b, "prom word address");
            chk(o_sysbus_sel === (k == 3), "system bus select");
        end
    endtask

    task automatic t_interleave();
        logic [15:0] rd;
        order = "";
        waits = 0;
        fork
            for (int k = 0; k < 3; k++) seq_access(17'h0_0100 + 17'(k), 16'h3c3c);
            for (int k = 0; k < 3; k++)
                ram(7'h05, 16'h4000 + 16'(2 * k), 1'b1, 1'b0, 16'h7e00 + 16'(k), 1'b0, rd);
        join
        chk(order.len() === 6, "completion count");
        for (int k = 1; k < order.len(); k++) chk(order[k] !== order[k - 1], "no alternation");
        chk(waits > 0, "processor never waited");
        ram(7'h05, 16'h4002, 1'b0, 1'b0, 16'h0000, 1'b0, rd);
        chk(rd === 16'h7e01, "interleaved data");
    endtask

    task automatic t_dma();
        logic [15:0] rd;
        ram(7'h03, 16'h0a0a, 1'b1, 1'b0, 16'h9669, 1'b1, rd);
        ram(7'h03, 16'h0a0a, 1'b0, 1'b0, 16'h0000, 1'b1, rd);
        chk(rd === 16'h9669, "dma data");
        repeat (2) @(posedge i_sys_clk);
        chk(o_dma_grant === 1'b0, "grant kept after release");
    endtask

    task automatic t_refresh();
        int f0 [6];
        f0 = falls;
        repeat (`REFRESH_CYCLES + 50) @(posedge i_sys_clk);
        chk(falls[5] + falls[4] > f0[5] + f0[4], "no refresh");
        chk(falls[3] === f0[3] && falls[2] === f0[2], "refresh strobed column");
    endtask

    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk) i_parity_clear <= 1'b0;
        chk(strb === 6'h3f && o_nmi_n === 1'b1 && o_parity_fault === 1'b0, "reset state");
        t_words();
        t_bytes();
        t_decode();
        t_interleave();
        t_dma();
        t_refresh();
        stop_test();
    end

    // about twenty times the expected run
    initial begin
        #400000;
        num_errors++;
        stop_test();
    end
endmodule
